// file: rtl/mmbs_pkg.sv
// package for the memory map and bank select block
// assumes a single core clock and synchronous active-high reset
`default_nettype none
package mmbs_pkg;
   localparam int PC_WIDTH = 13;
   localparam int WORD_WIDTH = 14;
   localparam int FULL_WORDS = 8192;
   localparam int SMALL_WORDS = 4096;
   localparam int BANK_WIDTH = 2;
   localparam int OFFSET_WIDTH = 7;
   localparam int DATA_ADDR_WIDTH = 9;
   localparam logic [12:0] RESET_VECTOR = 13'h0000;
   localparam logic [12:0] IRQ_VECTOR = 13'h0004;
   localparam int STATUS_BANK_HIGH_POS = 6;
   localparam int STATUS_BANK_LOW_POS = 5;
   localparam logic [6:0] BANK_TOP_OFFSET = 7'h7F;
   localparam logic [6:0] GPR_FIRST_OFFSET = 7'h20;
   localparam logic [6:0] COMMON_FIRST_OFFSET = 7'h70;
   localparam logic [6:0] INDIRECT_OFFSET = 7'h00;
   localparam logic [6:0] PCL_OFFSET = 7'h02;
   localparam logic [6:0] STATUS_OFFSET = 7'h03;
   localparam logic [6:0] POINTER_OFFSET = 7'h04;
   localparam logic [6:0] PCLATH_OFFSET = 7'h0A;
   localparam logic [6:0] INTCON_OFFSET = 7'h0B;

   // data access request from the core
   typedef struct packed {
      logic valid;
      logic indirect;
      logic [6:0] offset;
   } mmbs_data_req_type;

   // resolved data address
   typedef struct packed {
      logic [8:0] addr;
      logic isSfr;
      logic isGpr;
      logic isMirror;
   } mmbs_data_map_type;
endpackage : mmbs_pkg
`default_nettype wire

// file: rtl/mmbs_prog_rom.sv
// program word store with registered read data
// assumes the address is already folded into the implemented range
`default_nettype none
module mmbs_prog_rom
   import mmbs_pkg::*;
#(
   parameter int DEPTH = FULL_WORDS
) (
   input wire logic clk, // core clock
   input wire logic clkEn, // freezes state when low
   input wire logic [PC_WIDTH-1:0] rdAddr, // folded fetch address
   output logic [WORD_WIDTH-1:0] rdData, // registered instruction word
   input wire logic wrEn, // load strobe
   input wire logic [PC_WIDTH-1:0] wrAddr, // load address
   input wire logic [WORD_WIDTH-1:0] wrData // load word
);
   logic [WORD_WIDTH-1:0] mem [DEPTH];

   // one read port and one write port; contents need no reset
   always_ff @(posedge clk) begin
      if (clkEn) begin
         rdData <= mem[rdAddr[$clog2(DEPTH)-1:0]];
         if (wrEn) begin
            mem[wrAddr[$clog2(DEPTH)-1:0]] <= wrData;
         end
      end
   end
endmodule : mmbs_prog_rom
`default_nettype wire

// file: rtl/mmbs_memory_map.sv
// program counter, program fetch and data bank address mapping
// assumes the core drives fetch and data requests on clk, reset by sys_rst
// How it works
// - 13-bit counter spans 8K 14-bit words
// - large part 8K words, small 4K
// - addresses beyond implemented memory wrap around
// - reset starts fetch at 0000h
// - interrupt redirects fetch to 0004h
// - status bits 6:5 pick banks 0-3
// - each bank offsets 00h to 7Fh
// - special registers low, general RAM above
// - frequent special registers mirrored across banks
// - fetch and data paths run concurrently
// - data reached directly or through pointer
`default_nettype none
module mmbs_memory_map
   import mmbs_pkg::*;
#(
   parameter bit SMALL_VARIANT = 1'b0
) (
   input wire logic clk, // core clock, 125 MHz
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic clkEn, // freezes all state when low; sys_rst still clears counter and map
   input wire logic pcAdvance, // step to the next word
   input wire logic pcLoad, // branch to pcTarget
   input wire logic [PC_WIDTH-1:0] pcTarget, // branch target
   input wire logic irqTake, // interrupt accepted
   input wire logic [7:0] statusReg, // core status register value
   input wire logic [7:0] indirectPointerRegister, // indirect pointer value
   input wire mmbs_pkg::mmbs_data_req_type dataReq, // data access request
   input wire logic progWrEn, // program load strobe
   input wire logic [PC_WIDTH-1:0] progWrAddr, // program load address
   input wire logic [WORD_WIDTH-1:0] progWrData, // program load word
   output logic [PC_WIDTH-1:0] pcOut, // current program counter
   output logic [WORD_WIDTH-1:0] instrWord, // fetched word, registered
   output mmbs_pkg::mmbs_data_map_type dataMap, // resolved address, registered
   output logic dataMapValid // resolved address valid
);
   localparam int IMPL_WORDS = SMALL_VARIANT ? SMALL_WORDS : FULL_WORDS;
   localparam logic [PC_WIDTH-1:0] WRAP_MASK = PC_WIDTH'(IMPL_WORDS - 1);

   logic [PC_WIDTH-1:0] pc_reg;
   logic [PC_WIDTH-1:0] pc_next;
   logic [PC_WIDTH-1:0] fetchAddr;
   logic bankHigh;
   logic bankLow;
   logic [BANK_WIDTH-1:0] bankSel;
   logic [DATA_ADDR_WIDTH-1:0] directAddr;
   logic [DATA_ADDR_WIDTH-1:0] indirectAddr;
   logic [DATA_ADDR_WIDTH-1:0] effAddr;
   logic [OFFSET_WIDTH-1:0] effOffset;
   logic mirrored;
   mmbs_data_map_type map_next;
   mmbs_data_map_type map_reg;
   logic valid_reg;

   // counter next value: interrupt beats branch beats step
   assign pc_next = irqTake ? IRQ_VECTOR :
                    pcLoad ? pcTarget :
                    pcAdvance ? PC_WIDTH'(pc_reg + 13'h0001) : pc_reg;

   // full 13-bit counter kept; only the fetch and load addresses fold, like the real part
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pc_reg <= RESET_VECTOR;
      end else if (clkEn) begin
         pc_reg <= pc_next;
      end
   end

   // high counter bits ignored on the small part
   assign fetchAddr = pc_reg & WRAP_MASK;
   assign pcOut = pc_reg;

   // own fetch port, independent of the data path below
   mmbs_prog_rom #(
      .DEPTH(IMPL_WORDS)
   ) progRom (
      .clk(clk),
      .clkEn(clkEn),
      .rdAddr(fetchAddr),
      .rdData(instrWord),
      .wrEn(progWrEn),
      .wrAddr(progWrAddr & WRAP_MASK),
      .wrData(progWrData)
   );

   // bank select from status bits
   assign bankHigh = statusReg[STATUS_BANK_HIGH_POS];
   assign bankLow = statusReg[STATUS_BANK_LOW_POS];
   assign bankSel = {bankHigh, bankLow};
   assign directAddr = {bankSel, dataReq.offset};
   // indirect uses status bit 7 above the pointer, so all four banks reachable
   assign indirectAddr = {statusReg[7], indirectPointerRegister};
   assign effAddr = dataReq.indirect ? indirectAddr : directAddr;
   assign effOffset = effAddr[OFFSET_WIDTH-1:0];

   // registers shared by every bank, plus the common RAM window
   assign mirrored = (effOffset == INDIRECT_OFFSET) || (effOffset == PCL_OFFSET) ||
                     (effOffset == STATUS_OFFSET) || (effOffset == POINTER_OFFSET) ||
                     (effOffset == PCLATH_OFFSET) || (effOffset == INTCON_OFFSET) ||
                     (effOffset >= COMMON_FIRST_OFFSET);

   // classify and fold mirrored locations onto bank 0
   always_comb begin
      map_next.isSfr = (effOffset < GPR_FIRST_OFFSET);
      map_next.isGpr = (effOffset >= GPR_FIRST_OFFSET) &&
                       (effOffset <= BANK_TOP_OFFSET);
      map_next.isMirror = mirrored;
      map_next.addr = mirrored ? {2'h0, effOffset} : effAddr;
   end

   // registered address out so the data path has a whole cycle
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         map_reg <= '0;
         valid_reg <= 1'b0;
      end else if (clkEn) begin
         map_reg <= map_next;
         valid_reg <= dataReq.valid;
      end
   end

   assign dataMap = map_reg;
   assign dataMapValid = valid_reg;

   // checks
   int unsigned smallWords;
   assign smallWords = IMPL_WORDS;

   sequence irq_seen_s;
      clkEn && irqTake;
   endsequence

   reset_vector_a: assert property (@(posedge clk) $past(sys_rst) |-> pcOut == 13'h0000)
      else $error("counter not at reset vector");
   irq_vector_a: assert property (@(posedge clk) disable iff (sys_rst)
      irq_seen_s |=> pcOut == 13'h0004)
      else $error("interrupt did not go to 0004h");
   pc_step_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && pcAdvance && !pcLoad && !irqTake |=> pcOut == PC_WIDTH'($past(pcOut) + 1))
      else $error("counter did not step by one");
   fetch_wrap_a: assert property (@(posedge clk) fetchAddr < 13'(smallWords) ||
      smallWords == 8192)
      else $error("fetch address outside implemented memory");
   variant_size_a: assert property (@(posedge clk)
      smallWords == (SMALL_VARIANT ? 4096 : 8192))
      else $error("implemented size wrong");
   bank_direct_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && !dataReq.indirect && !mirrored |=>
      dataMap.addr == {$past(statusReg[6]), $past(statusReg[5]), $past(dataReq.offset)})
      else $error("direct address not bank over offset");
   sfr_gpr_split_a: assert property (@(posedge clk) disable iff (sys_rst)
      dataMapValid |-> (dataMap.isSfr != dataMap.isGpr))
      else $error("location both or neither special and general");
   mirror_fold_a: assert property (@(posedge clk) disable iff (sys_rst)
      dataMapValid && dataMap.isMirror |-> dataMap.addr[8:7] == 2'h0)
      else $error("mirrored location not folded to bank 0");
   indirect_path_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && dataReq.indirect && !mirrored |=>
      dataMap.addr == {$past(statusReg[7]), $past(indirectPointerRegister)})
      else $error("indirect address wrong");

   // a frozen cycle outside reset: the next edge must change nothing
   sequence frozen_s;
      !clkEn && !sys_rst;
   endsequence

   // a direct data request taken while the clock runs
   sequence direct_req_s;
      clkEn && !dataReq.indirect;
   endsequence

   // a low enable holds counter and map, so the core can stall freely
   freeze_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      frozen_s |=> $stable(pcOut) && $stable(dataMap) && $stable(dataMapValid))
      else $error("state moved while clock enable low");

   // reset wins over a low enable and clears the counter and the map, but not instrWord
   reset_clear_a: assert property (@(posedge clk)
      sys_rst |=> pcOut == RESET_VECTOR && !dataMapValid && dataMap == '0)
      else $error("reset did not clear counter and map");

   // a branch without interrupt lands exactly on its target
   load_branch_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && pcLoad && !irqTake |=> pcOut == $past(pcTarget))
      else $error("branch did not load target");

   // no request at all leaves the counter where it is
   pc_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && !pcAdvance && !pcLoad && !irqTake |=> $stable(pcOut))
      else $error("counter moved without request");

   // on a direct request the low seven address bits always carry the instruction offset
   bank_offset_a: assert property (@(posedge clk) disable iff (sys_rst)
      direct_req_s |=> dataMap.addr[OFFSET_WIDTH-1:0] == $past(dataReq.offset))
      else $error("offset lost in direct address");

   // low offsets are special registers in any bank
   sfr_low_a: assert property (@(posedge clk) disable iff (sys_rst)
      direct_req_s ##0 (dataReq.offset < GPR_FIRST_OFFSET) |=>
      dataMap.isSfr && !dataMap.isGpr)
      else $error("low offset not special register");

   // offsets from the first general slot up are plain RAM
   gpr_high_a: assert property (@(posedge clk) disable iff (sys_rst)
      direct_req_s ##0 (dataReq.offset >= GPR_FIRST_OFFSET) |=>
      dataMap.isGpr && !dataMap.isSfr)
      else $error("high offset not general register");

   // status is reachable from every bank at one physical place
   mirror_status_a: assert property (@(posedge clk) disable iff (sys_rst)
      direct_req_s ##0 (dataReq.offset == STATUS_OFFSET) |=>
      dataMap.addr == {2'h0, STATUS_OFFSET} && dataMap.isMirror)
      else $error("status not mirrored to one place");

   // a fetch step and a data access complete in the same cycle
   concurrent_paths_a: assert property (@(posedge clk) disable iff (sys_rst)
      clkEn && dataReq.valid && pcAdvance && !pcLoad && !irqTake |=>
      dataMapValid && pcOut == PC_WIDTH'($past(pcOut) + 1))
      else $error("fetch and data did not run together");
endmodule : mmbs_memory_map
`default_nettype wire

// file: dv/mmbs_core_model.sv
// core-side model: loads a known program image through the load port
// assumes the bench raises go after reset; word at address a is 3A00h plus a
`default_nettype none
module mmbs_core_model
   import mmbs_pkg::*;
(
   input wire logic clk, // core clock
   input wire logic go, // start image load
   output logic wrEn, // load strobe
   output logic [PC_WIDTH-1:0] wrAddr, // load address
   output logic [WORD_WIDTH-1:0] wrData, // load word
   output logic done // image loaded
);
   timeunit 1ns;
   timeprecision 1ps;
   // eight words only: enough for both vectors and the folded fetch
   initial begin
      wrEn = 1'b0;
      wrAddr = '0;
      wrData = '0;
      done = 1'b0;
      wait (go === 1'b1);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk);
         wrEn <= 1'b1;
         wrAddr <= PC_WIDTH'(i);
         wrData <= WORD_WIDTH'(i) + 14'h3A00;
      end
      @(posedge clk);
      wrEn <= 1'b0;
      wrData <= ~wrData; // released bus shows no stale word
      done <= 1'b1;
   end
endmodule : mmbs_core_model
`default_nettype wire

// file: dv/memory_map_and_bank_select_tb.sv
// self-checking bench for the memory map, small variant so folding shows
// assumes mmbs_core_model loads the image; clkEn is dropped only in test_freeze
`default_nettype none
module memory_map_and_bank_select_tb;
   import mmbs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, sys_rst, pcAdvance, pcLoad, irqTake, progWrEn, dataMapValid, go, done;
   logic clkEn;
   logic [12:0] pcTarget, progWrAddr, pcOut;
   logic [13:0] progWrData, instrWord;
   logic [7:0] statusReg, ptr;
   mmbs_data_req_type dataReq;
   mmbs_data_map_type dataMap;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   mmbs_memory_map #(.SMALL_VARIANT(1'b1)) dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
      .pcAdvance(pcAdvance), .pcLoad(pcLoad), .pcTarget(pcTarget), .irqTake(irqTake),
      .statusReg(statusReg), .indirectPointerRegister(ptr), .dataReq(dataReq),
      .progWrEn(progWrEn), .progWrAddr(progWrAddr), .progWrData(progWrData), .pcOut(pcOut),
      .instrWord(instrWord), .dataMap(dataMap), .dataMapValid(dataMapValid));
   mmbs_core_model core (.clk(clk), .go(go), .wrEn(progWrEn), .wrAddr(progWrAddr),
      .wrData(progWrData), .done(done));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic report_and_stop;
      if (miscompares == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : report_and_stop
   // one request, judged just after the edge that registers it
   task automatic map_check(input logic [7:0] st, input logic ind, input logic [6:0] off,
         input logic [11:0] exp);
      @(posedge clk);
      statusReg <= st;
      dataReq <= '{valid: 1'b1, indirect: ind, offset: off};
      @(posedge clk);
      dataReq.valid <= 1'b0;
      #1;
      check("dataMap", 16'(dataMap), 16'(exp));
      check("dataMapValid", 16'(dataMapValid), 16'h0001);
   endtask : map_check
   // irq and branch together: the vector must win
   task automatic test_irq;
      @(posedge clk);
      irqTake <= 1'b1;
      pcLoad <= 1'b1;
      pcTarget <= 13'h0007;
      @(posedge clk);
      irqTake <= 1'b0;
      pcLoad <= 1'b0;
      #1;
      check("pcOut", 16'(pcOut), 16'h0004);
      @(posedge clk);
      #1;
      check("instrWord", 16'(instrWord), 16'h3A04);
   endtask : test_irq
   // fetch above 4K folds down; counter itself wraps at 13 bits
   task automatic test_wrap;
      @(posedge clk);
      pcLoad <= 1'b1;
      pcTarget <= 13'h1006;
      @(posedge clk);
      pcLoad <= 1'b0;
      pcAdvance <= 1'b1;
      #1;
      check("pcOut", 16'(pcOut), 16'h1006);
      @(posedge clk);
      pcAdvance <= 1'b0;
      pcLoad <= 1'b1;
      pcTarget <= 13'h1FFF;
      #1;
      check("instrWord", 16'(instrWord), 16'h3A06);
      @(posedge clk);
      pcLoad <= 1'b0;
      pcAdvance <= 1'b1;
      @(posedge clk);
      pcAdvance <= 1'b0;
      #1;
      check("pcOut", 16'(pcOut), 16'h0000);
   endtask : test_wrap
   task automatic test_banks;
      for (int b = 0; b < 4; b++) begin
         map_check({1'b0, 2'(b), 5'h00}, 1'b0, 7'h25, {2'(b), 7'h25, 3'b010});
      end
   endtask : test_banks
   // region edges, mirrors and the pointer path
   task automatic test_special;
      map_check(8'h20, 1'b0, 7'h1F, {2'b01, 7'h1F, 3'b100});
      map_check(8'h20, 1'b0, 7'h20, {2'b01, 7'h20, 3'b010});
      map_check(8'h60, 1'b0, 7'h03, {2'b00, 7'h03, 3'b101});
      map_check(8'h40, 1'b0, 7'h7F, {2'b00, 7'h7F, 3'b011});
      map_check(8'h80, 1'b1, 7'h00, {9'h145, 3'b010});
   endtask : test_special
   // low enable freezes state; a mid-run reset still acts while frozen
   task automatic test_freeze;
      @(posedge clk);
      clkEn <= 1'b0;
      pcAdvance <= 1'b1;
      dataReq <= '{valid: 1'b1, indirect: 1'b0, offset: 7'h30};
      repeat (2) @(posedge clk);
      #1;
      check("pcOut", 16'(pcOut), 16'h0000);
      check("dataMapValid", 16'(dataMapValid), 16'h0000);
      @(posedge clk);
      clkEn <= 1'b1;
      @(posedge clk);
      clkEn <= 1'b0;
      sys_rst <= 1'b1;
      #1;
      check("pcOut", 16'(pcOut), 16'h0001);
      check("dataMapValid", 16'(dataMapValid), 16'h0001);
      @(posedge clk);
      sys_rst <= 1'b0;
      pcAdvance <= 1'b0;
      dataReq <= '0;
      clkEn <= 1'b1;
      #1;
      check("pcOut", 16'(pcOut), 16'h0000);
      check("dataMapValid", 16'(dataMapValid), 16'h0000);
   endtask : test_freeze
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // hang guard, generous against the 44 cycles needed
   always @(posedge clk) begin
      cycles++;
      if (cycles == 2000) begin
         miscompares++;
         report_and_stop();
      end
   end
   initial begin
      {pcAdvance, pcLoad, irqTake, go} = 4'h0;
      clkEn = 1'b1;
      pcTarget = 13'h0000;
      statusReg = 8'h00;
      ptr = 8'h45;
      dataReq = '0;
      sys_rst = 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      go <= 1'b1;
      #1;
      check("pcOut", 16'(pcOut), 16'h0000);
      check("dataMapValid", 16'(dataMapValid), 16'h0000);
      wait (done === 1'b1);
      @(posedge clk);
      #1;
      check("instrWord", 16'(instrWord), 16'h3A00);
      test_irq();
      test_wrap();
      test_banks();
      test_special();
      test_freeze();
      report_and_stop();
   end
endmodule : memory_map_and_bank_select_tb
`default_nettype wire
